/* File: core/ocsl_baud_nco.v */
// phase accumulator that makes one baud reference clock
`timescale 1ns/1ns
module ocsl_baud_nco #(
	parameter [23:0] STEP = 24'h000001
) (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// clock out
	output reg clk_out
);
`include "ocsl_regs.vh"
reg [`OCSL_PHASE_BITS-1:0] phase;
// carry out gives one tick per reference period; a square wave taken from the
// top phase bit would alias once the rate passes half the bus clock
wire [`OCSL_PHASE_BITS:0] sum = {1'b0, phase} + {1'b0, STEP};
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		phase <= 24'h000000;
		clk_out <= 1'b0;
	end else begin
		phase <= sum[`OCSL_PHASE_BITS-1:0];
		clk_out <= sum[`OCSL_PHASE_BITS];
	end
end
endmodule

/* File: core/ocsl_card.v */
// octal serial card address decode, strap sampling and uart setup
`timescale 1ns/1ns
module ocsl_card (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// host i/o cycle
	input wire io_req,
	input wire io_wr,
	input wire [15:0] io_addr,
	input wire [7:0] io_wdata,
	output reg io_ack,
	output reg [7:0] io_rdata,
	// host configuration cycle
	input wire cfg_req,
	input wire cfg_wr,
	input wire [5:0] cfg_dword,
	input wire [31:0] cfg_wdata,
	output reg cfg_ack,
	output reg [31:0] cfg_rdata,
	// host interrupt line, low while asserted
	output reg host_int_n,
	// uart bus
	output reg uart_cs_n,
	output reg uart_wr_n,
	output reg uart_rd_n,
	output reg [2:0] uart_chan,
	output reg [3:0] uart_addr,
	output reg [7:0] uart_wdata,
	input wire [7:0] uart_rdata,
	input wire [7:0] uart_int,
	// straps, high when the jumper is in
	input wire [7:0] line_mode_strap_first,
	input wire [7:0] line_mode_strap_second,
	input wire [7:0] auto_direction_strap,
	input wire eightfold_baud_range_strap,
	// per channel line mode and direction, shared baud reference
	output reg [15:0] line_mode,
	output reg [7:0] automatic_transmit_direction_alias,
	output reg uart_baud_clk,
	// setup finished
	output reg init_done
);
`include "ocsl_regs.vh"
localparam [63:0] STEP_X1_FULL = (`OCSL_BAUD_REF_HZ * 64'd16777216) / `OCSL_CLK_HZ;
localparam [63:0] STEP_X8_FULL = (`OCSL_BAUD_REF_HZ * 64'd134217728) / `OCSL_CLK_HZ;
localparam [23:0] STEP_X1 = STEP_X1_FULL[23:0]; // RULE_09
localparam [23:0] STEP_X8 = STEP_X8_FULL[23:0]; // RULE_11
localparam [1:0] ST_INIT = 2'h0;
localparam [1:0] ST_IDLE = 2'h1;
localparam [1:0] ST_XFER = 2'h2;
localparam [1:0] ST_DONE = 2'h3;
// ---------------------------------------------
// pin synchronisers
// ---------------------------------------------
reg [24:0] strap_s1, strap_s2;
reg [7:0] int_s1, int_s2;
reg [7:0] rdata_s1, rdata_s2;
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		strap_s1 <= 25'h0000000;
		strap_s2 <= 25'h0000000;
		int_s1 <= 8'h00;
		int_s2 <= 8'h00;
		rdata_s1 <= 8'h00;
		rdata_s2 <= 8'h00;
	end else begin
		strap_s1 <= {eightfold_baud_range_strap, auto_direction_strap,
			line_mode_strap_second, line_mode_strap_first};
		strap_s2 <= strap_s1;
		int_s1 <= uart_int;
		int_s2 <= int_s1;
		rdata_s1 <= uart_rdata;
		rdata_s2 <= rdata_s1;
	end
end
// ---------------------------------------------
// baud reference
// ---------------------------------------------
wire ref_x1, ref_x8;
ocsl_baud_nco #(.STEP(STEP_X1)) u_nco_x1 (.clk(clk), .reset_n(reset_n), .clk_out(ref_x1));
ocsl_baud_nco #(.STEP(STEP_X8)) u_nco_x8 (.clk(clk), .reset_n(reset_n), .clk_out(ref_x8));
// ---------------------------------------------
// state and registers
// ---------------------------------------------
reg [1:0] state;
reg [3:0] settle;
reg [3:0] chan_idx;
reg [3:0] wait_cnt;
reg [7:0] dir_latched;
reg range_x8;
reg bar_io_en;
reg [15:0] bar_base;
reg [7:0] irq_line;
reg pend_rd;
integer i;
wire [15:0] ofs = io_addr - bar_base;
wire hit = bar_io_en && (io_addr[15:7] == bar_base[15:7]); // RULE_12 RULE_13
wire hit_chan = hit && (ofs[6:0] <= `OCSL_CHAN_LAST_OFS); // RULE_01
wire hit_isr = hit && (ofs[6:0] == `OCSL_ISR_OFS); // RULE_02
// mode decode per channel, first strap in high bit
function [1:0] mode_of;
	input f;
	input s;
	begin
		case ({f, s})
			2'b10: mode_of = `OCSL_MODE_485_2W;
			2'b01: mode_of = `OCSL_MODE_485_4W;
			2'b11: mode_of = `OCSL_MODE_422;
			default: mode_of = `OCSL_MODE_232;
		endcase
	end
endfunction
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		state <= ST_INIT;
		settle <= 4'h0;
		chan_idx <= 4'h0;
		wait_cnt <= 4'h0;
		dir_latched <= 8'h00;
		range_x8 <= 1'b0;
		line_mode <= 16'h0000;
		automatic_transmit_direction_alias <= 8'h00;
		bar_io_en <= 1'b0;
		bar_base <= 16'h0000;
		irq_line <= 8'h00;
		io_ack <= 1'b0;
		io_rdata <= 8'h00;
		cfg_ack <= 1'b0;
		cfg_rdata <= 32'h00000000;
		host_int_n <= 1'b1;
		uart_cs_n <= 1'b1;
		uart_wr_n <= 1'b1;
		uart_rd_n <= 1'b1;
		uart_chan <= 3'h0;
		uart_addr <= 4'h0;
		uart_wdata <= 8'h00;
		uart_baud_clk <= 1'b0;
		init_done <= 1'b0;
		pend_rd <= 1'b0;
	end else begin
		io_ack <= 1'b0;
		cfg_ack <= 1'b0;
		host_int_n <= ~(|int_s2); // RULE_16
		uart_baud_clk <= range_x8 ? ref_x8 : ref_x1; // RULE_10 RULE_11
		// configuration space
		if (cfg_req && !cfg_ack) begin
			cfg_ack <= 1'b1;
			cfg_rdata <= 32'h00000000;
			case (cfg_dword)
				`OCSL_CFG_ID_OFS: cfg_rdata <= {`OCSL_DEVICE_ID, `OCSL_VENDOR_ID}; // RULE_14
				`OCSL_CFG_CMD_OFS: begin
					cfg_rdata <= {31'h00000000, bar_io_en};
					if (cfg_wr)
						bar_io_en <= cfg_wdata[`OCSL_CMD_IO_BIT];
				end
				`OCSL_CFG_BAR_OFS: begin
					// bit 0 high marks an i/o space window
					cfg_rdata <= {16'h0000, bar_base[15:1], 1'b1};
					if (cfg_wr)
						bar_base <= cfg_wdata[15:0] & `OCSL_BAR_MASK; // RULE_13
				end
				`OCSL_CFG_IRQ_OFS: begin
					cfg_rdata <= {24'h000108, irq_line};
					if (cfg_wr)
						irq_line <= cfg_wdata[7:0];
				end
				default: cfg_rdata <= 32'h00000000;
			endcase
		end
		case (state)
			ST_INIT: begin
				// let the strap synchronisers fill, then latch once
				settle <= settle + 4'h1;
				if (settle == 4'h3) begin
					dir_latched <= strap_s2[23:16]; // RULE_06
					range_x8 <= strap_s2[24]; // RULE_11
					for (i = 0; i < 8; i = i + 1)
						line_mode[2*i +: 2] <= mode_of(strap_s2[i], strap_s2[8+i]); // RULE_07
					chan_idx <= 4'h0;
					wait_cnt <= 4'h0;
					state <= ST_DONE;
				end
			end
			ST_DONE: begin
				// one extended write per channel, no host i/o access meanwhile
				uart_cs_n <= 1'b0;
				uart_chan <= chan_idx[2:0];
				uart_addr <= {1'b1, `OCSL_EXT_DIR_OFS}; // RULE_05
				uart_wdata <= (dir_latched[chan_idx[2:0]] &&
					line_mode[2*chan_idx[2:0] +: 2] == `OCSL_MODE_485_2W) ?
					`OCSL_EXT_DIR_ON : `OCSL_EXT_DIR_OFF; // RULE_08
				uart_wr_n <= (wait_cnt == `OCSL_WR_CYCLES);
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt == `OCSL_WR_CYCLES) begin
					uart_cs_n <= 1'b1;
					automatic_transmit_direction_alias[chan_idx[2:0]] <=
						dir_latched[chan_idx[2:0]] &&
						line_mode[2*chan_idx[2:0] +: 2] == `OCSL_MODE_485_2W;
					wait_cnt <= 4'h0;
					chan_idx <= chan_idx + 4'h1;
					if (chan_idx == 4'h7) begin
						init_done <= 1'b1;
						state <= ST_IDLE;
					end
				end
			end
			ST_IDLE: begin
				if (io_req && !io_ack && hit_isr) begin
					io_ack <= 1'b1;
					io_rdata <= io_wr ? 8'h00 : int_s2; // RULE_03 RULE_17
				end else if (io_req && !io_ack && hit_chan) begin
					uart_cs_n <= 1'b0;
					uart_chan <= ofs[5:3];
					uart_addr <= {1'b0, ofs[2:0]}; // RULE_04 RULE_15
					uart_wdata <= io_wdata;
					uart_wr_n <= ~io_wr;
					uart_rd_n <= io_wr;
					pend_rd <= ~io_wr;
					wait_cnt <= 4'h0;
					state <= ST_XFER;
				end else if (io_req && !io_ack && hit) begin
					io_ack <= 1'b1;
					io_rdata <= 8'h00;
				end
			end
			ST_XFER: begin
				// strobe held, then sample read data through the synchroniser
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt == `OCSL_WR_CYCLES) begin
					uart_cs_n <= 1'b1;
					uart_wr_n <= 1'b1;
					uart_rd_n <= 1'b1;
					io_ack <= 1'b1;
					io_rdata <= pend_rd ? rdata_s2 : 8'h00;
					state <= ST_IDLE;
				end
			end
			default: state <= ST_INIT;
		endcase
	end
end
endmodule

/* File: core/ocsl_regs.vh */
// constants for the octal serial card address and strap logic
// Operation
// RULE_01: the eight channels occupy window offsets 00h..3Fh, eight locations each, in order.
// RULE_02: the combined interrupt status register decodes at window offset 40h.
// RULE_03: reading the status register shows which channels have an interrupt pending.
// RULE_04: host offsets reach only the eight standard registers of each channel, never the extended ones.
// RULE_05: after each reset the block writes the extended registers that set automatic direction.
// RULE_06: the direction straps are sampled only at reset and changes wait for the next reset.
// RULE_07: two line mode straps select 2-wire RS485, 4-wire RS485, RS422 or RS232 per channel.
// RULE_08: channels are configured independently and automatic direction applies only in 2-wire RS485.
// RULE_09: the UART baud reference runs at 1.8432 MHz.
// RULE_10: divisor 1 gives 115200 baud in the normal range and 921600 in the eightfold range.
// RULE_11: the range strap feeds the UART an eightfold clock, otherwise the normal clock.
// RULE_12: the block claims exactly one I/O space holding channels and status register.
// RULE_13: the host places the base anywhere in the 64K I/O space; no strap chooses it.
// RULE_14: 16-bit vendor and device codes appear in configuration space.
// RULE_15: each visible group acts as a plain 16550/16750 compatible UART.
// RULE_16: all channel interrupts combine onto the single host interrupt line.
// RULE_17: bit n of the status register reports channel n, and reading it has no side effect.
`ifndef OCSL_REGS_VH
`define OCSL_REGS_VH
// ---------------------------------------------
// window layout
// ---------------------------------------------
`define OCSL_CHAN_LAST_OFS 7'h3F
`define OCSL_ISR_OFS 7'h40
`define OCSL_WIN_SIZE 17'h00080
`define OCSL_BAR_MASK 16'hFF80
// ---------------------------------------------
// configuration space
// ---------------------------------------------
`define OCSL_CFG_ID_OFS 6'h00
`define OCSL_CFG_CMD_OFS 6'h01
`define OCSL_CFG_BAR_OFS 6'h04
`define OCSL_CFG_IRQ_OFS 6'h0F
// identity codes: arbitrary values
`define OCSL_VENDOR_ID 16'h1234
`define OCSL_DEVICE_ID 16'h5678
`define OCSL_CMD_IO_BIT 0
// ---------------------------------------------
// uart extended register programming
// ---------------------------------------------
`define OCSL_EXT_BIT 3
`define OCSL_EXT_DIR_OFS 3'h3
`define OCSL_EXT_DIR_ON 8'h20
`define OCSL_EXT_DIR_OFF 8'h00
// ---------------------------------------------
// line modes
// ---------------------------------------------
`define OCSL_MODE_485_2W 2'h0
`define OCSL_MODE_485_4W 2'h1
`define OCSL_MODE_422 2'h2
`define OCSL_MODE_232 2'h3
// ---------------------------------------------
// timing
// ---------------------------------------------
`define OCSL_BAUD_REF_HZ 1843200
`define OCSL_CLK_HZ 25000000
`define OCSL_PHASE_BITS 24
`define OCSL_WR_CYCLES 4'h3
`endif

/* File: verification/ocsl_card_properties.sv */
// assertion checker for the octal serial card glue
`timescale 1ns/1ns
module ocsl_card_properties (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// host side
	input wire [15:0] io_addr,
	input wire io_ack,
	input wire host_int_n,
	// uart side
	input wire uart_cs_n,
	input wire uart_wr_n,
	input wire [2:0] uart_chan,
	input wire [3:0] uart_addr,
	input wire [7:0] uart_wdata,
	input wire [7:0] uart_int,
	// straps decoded
	input wire [15:0] line_mode,
	input wire [7:0] automatic_transmit_direction_alias,
	input wire init_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_INT_SET: assert property ((|uart_int)[*5] |-> !host_int_n)
		else $error("host interrupt not asserted");
	AST_INT_IDLE: assert property ((uart_int == 8'h00)[*5] |-> host_int_n)
		else $error("host interrupt without cause");
	AST_NO_EXT: assert property (init_done && !uart_cs_n |-> !uart_addr[3])
		else $error("extended bank reached by host");
	AST_EXT_ADDR: assert property (!init_done && !uart_wr_n |-> uart_addr == 4'hB)
		else $error("setup write to wrong register");
	AST_DIR_2W: assert property (!init_done && !uart_wr_n && uart_wdata == 8'h20
		|-> line_mode[{uart_chan, 1'b0}+:2] == 2'h0)
		else $error("auto direction outside two wire mode");
	AST_CHAN_MAP: assert property ($fell(uart_cs_n) && init_done
		|-> {uart_chan, uart_addr[2:0]} == io_addr[5:0])
		else $error("channel or register map wrong");
	AST_STROBE: assert property ($fell(uart_cs_n) && init_done
		|-> !uart_cs_n[*4] ##1 (uart_cs_n && io_ack))
		else $error("uart strobe shape wrong");
	AST_ACK_PULSE: assert property (io_ack |=> !io_ack)
		else $error("ack longer than one cycle");
	AST_PRE_INIT: assert property (!init_done |-> !io_ack)
		else $error("ack before setup done");
	AST_STRAP_HOLD: assert property (init_done |=>
		$stable(automatic_transmit_direction_alias))
		else $error("direction changed without reset");
endmodule

/* File: verification/ocsl_uart_model.sv */
// behavioural model of the octal uart behind the card
`timescale 1ns/1ns
module ocsl_uart_model (
	// clock
	input wire clk,
	// uart bus
	input wire cs_n,
	input wire wr_n,
	input wire rd_n,
	input wire [2:0] chan,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	output wire [7:0] rdata
);
	reg [7:0] mem [0:127];
	reg [7:0] last;
	// released bus shows the inverse of the last value
	assign rdata = (!cs_n && !rd_n) ? mem[{chan, addr}] : ~last;
	initial last = 8'h00;
	always @(posedge clk) begin
		if (!cs_n && !wr_n) mem[{chan, addr}] <= wdata;
		if (!cs_n && !rd_n) last <= mem[{chan, addr}];
	end
endmodule

/* File: verification/tb.sv */
// self-checking bench for the octal serial card glue
`timescale 1ns/1ns
`include "ocsl_regs.vh"
module tb;
	reg clk, reset_n, io_req, io_wr, cfg_req, cfg_wr, x8, ok;
	reg [15:0] io_addr, base;
	reg [7:0] io_wdata, uint, sf, ss, sa, q, ea;
	reg [5:0] cfg_dword;
	reg [31:0] cfg_wdata, r, c32;
	wire io_ack, cfg_ack, host_int_n, cs_n, wr_n, rd_n, ubclk, init_done;
	wire [7:0] io_rdata, urd, adir, uwd;
	wire [31:0] cfg_rdata;
	wire [2:0] uch;
	wire [3:0] uad;
	wire [15:0] lmode;
	integer bad_count, n_checks, i, p, k, nb;
	ocsl_card dut (.clk(clk), .reset_n(reset_n), .io_req(io_req), .io_wr(io_wr),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_ack(io_ack), .io_rdata(io_rdata),
		.cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_dword(cfg_dword), .cfg_wdata(cfg_wdata),
		.cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .host_int_n(host_int_n),
		.uart_cs_n(cs_n), .uart_wr_n(wr_n), .uart_rd_n(rd_n), .uart_chan(uch),
		.uart_addr(uad), .uart_wdata(uwd), .uart_rdata(urd), .uart_int(uint),
		.line_mode_strap_first(sf), .line_mode_strap_second(ss),
		.auto_direction_strap(sa), .eightfold_baud_range_strap(x8), .line_mode(lmode),
		.automatic_transmit_direction_alias(adir), .uart_baud_clk(ubclk),
		.init_done(init_done));
	ocsl_uart_model um (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .chan(uch),
		.addr(uad), .wdata(uwd), .rdata(urd));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [1:0] emode(input f, input s);
		emode = f ? (s ? 2'h2 : 2'h0) : (s ? 2'h1 : 2'h3);
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("mismatch at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", n_checks, bad_count);
			if (bad_count == 0 && n_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task io(input w, input [15:0] a, input [7:0] d, input e);
		begin
			io_wr <= w;
			io_addr <= a;
			io_wdata <= d;
			io_req <= 1'b1;
			ok = 0;
			for (k = 0; k < 12 && !ok; k = k + 1) begin
				@(posedge clk);
				q = io_rdata;
				ok = io_ack === 1'b1;
			end
			io_req <= 1'b0;
			@(posedge clk);
			chk(ok, e);
		end
	endtask
	task cfg(input w, input [5:0] d, input [31:0] v);
		begin
			cfg_wr <= w;
			cfg_dword <= d;
			cfg_wdata <= v;
			cfg_req <= 1'b1;
			ok = 0;
			for (k = 0; k < 8 && !ok; k = k + 1) begin
				@(posedge clk);
				c32 = cfg_rdata;
				ok = cfg_ack === 1'b1;
			end
			cfg_req <= 1'b0;
			@(posedge clk);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (ubclk === 1'b1) nb = nb + 1;
	initial begin
		#400000;
		bad_count = bad_count + 1;
		wrap_up;
	end
	initial begin
		{reset_n, io_req, io_wr, cfg_req, cfg_wr, x8, io_addr, io_wdata} = 0;
		{uint, sf, ss, sa, cfg_dword, cfg_wdata, base} = 0;
		bad_count = 0;
		n_checks = 0;
		r = 32'hDF4A9A5C;
		for (p = 0; p < 2; p = p + 1) begin
			r = lfsr(r);
			{x8, sa, ss, sf} <= r[24:0];
			base = p ? 16'hFF80 : r[31:16] & 16'hFF80;
			reset_n <= 1'b0;
			repeat (4) @(posedge clk);
			reset_n <= 1'b1;
			cfg(1'b1, 6'h01, 32'h1);
			cfg(1'b1, 6'h04, {16'h0, base});
			io(1'b0, base + 16'h40, 8'h00, 1'b0);
			for (k = 0; k < 100 && init_done !== 1'b1; k = k + 1) @(posedge clk);
			cfg(1'b0, 6'h00, 32'h0);
			chk(c32, {`OCSL_DEVICE_ID, `OCSL_VENDOR_ID});
			cfg(1'b0, 6'h04, 32'h0);
			chk(c32, {16'h0000, base[15:1], 1'b1});
			for (i = 0; i < 8; i = i + 1) begin
				ea[i] = sa[i] && emode(sf[i], ss[i]) == 2'h0;
				chk(lmode[2*i+:2], emode(sf[i], ss[i]));
				chk(um.mem[{i[2:0], 4'hB}], ea[i] ? `OCSL_EXT_DIR_ON : `OCSL_EXT_DIR_OFF);
			end
			chk(adir, ea);
			sa <= ~sa;
			sf <= ~sf;
			for (i = 0; i < 8; i = i + 1) begin
				r = lfsr(r);
				io(1'b1, base + {i[2:0], r[2:0]}, r[15:8], 1'b1);
				chk(um.mem[{i[2:0], 1'b0, r[2:0]}], r[15:8]);
				io(1'b0, base + {i[2:0], r[2:0]}, 8'h00, 1'b1);
				chk(q, r[15:8]);
				uint <= 8'h01 << i;
				repeat (5) @(posedge clk);
				chk(host_int_n, 1'b0);
				io(1'b0, base + 16'h40, 8'h00, 1'b1);
				chk(q, 8'h01 << i);
			end
			chk(adir, ea);
			uint <= r[23:16];
			io(1'b1, base + 16'h40, 8'hA5, 1'b1);
			repeat (2) io(1'b0, base + 16'h40, 8'h00, 1'b1);
			chk(q, r[23:16]);
			uint <= 8'h00;
			io(1'b0, base + 16'h41, 8'h00, 1'b1);
			chk(q, 8'h00);
			io(1'b0, base + 16'h80, 8'h00, 1'b0);
			io(1'b0, base - 16'h1, 8'h00, 1'b0);
			chk(host_int_n, 1'b1);
			nb = 0;
			repeat (1250) @(posedge clk);
			k = x8 ? 737 : 92;
			chk((nb - k) * (nb - k) <= 4, 1'b1);
			$display("pass %0d done", p);
		end
		wrap_up;
	end
endmodule
bind ocsl_card ocsl_card_properties chk_i (.clk(clk), .reset_n(reset_n),
	.io_addr(io_addr), .io_ack(io_ack), .host_int_n(host_int_n), .uart_cs_n(uart_cs_n),
	.uart_wr_n(uart_wr_n), .uart_chan(uart_chan), .uart_addr(uart_addr),
	.uart_wdata(uart_wdata), .uart_int(uart_int), .line_mode(line_mode),
	.automatic_transmit_direction_alias(automatic_transmit_direction_alias),
	.init_done(init_done));
